// ### core/cbc_bus_controller.sv
// Bus command controller: decodes CPU status into command strobes and transceiver controls.
// Assumes status, grant, gate and mode inputs are synchronous to core_clk, the CPU clock.
// Overview of operation
// - Floating status bus reads as all ones, the passive code.
// - Every output changes only on the core clock edge.
// - One address strobe pulse per cycle; latch takes address on its falling edge.
// - Transceiver enable is active high.
// - Direction is high for writes and low for reads.
// - System bus mode: grant high floats every command output.
// - I/O bus mode: grant high floats only memory command outputs.
// - After grant falls, floated commands stay inactive at least 90 ns.
// - Gate low forces commands, transceiver enable and peripheral enable inactive.
// - Mode select high means I/O bus mode, low means system bus mode.
// - All seven commands are active low and three-state capable.
// - Early I/O write asserts one clock before normal I/O write.
// - I/O read strobe asserts during I/O read cycles.
// - Status codes decode to acknowledge, I/O, halt, fetch, memory and passive.
// - Dual enable: cascade enable in system mode, peripheral enable in I/O mode.
// - Early memory write asserts one clock before normal memory write.
// - Address strobe is issued once per cycle starting with non-passive status.
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_controller
  import cbc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = GRANT_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cpu_status_bit0_n,
  input wire logic cpu_status_bit1_n,
  input wire logic cpu_status_bit2_n,
  input wire logic cpu_status_float,
  input wire logic arbiter_grant_n,
  input wire logic command_gate,
  input wire logic io_bus_mode_select,
  output cbc_cmd_t cmd_n,
  output cbc_cmd_t cmd_oe_n,
  output logic address_strobe,
  output logic transceiver_enable,
  output logic transceiver_direction,
  output logic dual_enable
);
  logic [2:0] status;
  logic [2:0] status_prev_r;
  logic grant_ok;
  logic mem_ok;
  logic io_ok;
  cbc_phase_t phase_r;
  cbc_phase_t phase_nxt;
  cbc_kind_t kind_r;
  cbc_kind_t kind_nxt;
  cbc_kind_t kind_dec;
  cbc_cmd_t cmd_nxt;
  logic early;
  logic late;

  // The pull-ups are modelled by the float flag: an undriven bus reads passive.
  assign status = cpu_status_float ? ST_PASSIVE
                : {cpu_status_bit2_n, cpu_status_bit1_n, cpu_status_bit0_n};

  cbc_grant_delay #(
    .HOLD_CYC(HOLD_CYC)
  ) u_grant_delay (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .arbiter_grant_n(arbiter_grant_n),
    .grant_ok(grant_ok)
  );

  // I/O commands ignore the grant in I/O bus mode; memory commands never do.
  assign mem_ok = grant_ok && command_gate;
  assign io_ok = (io_bus_mode_select || grant_ok) && command_gate;

  always_comb begin
    unique case (status)
      ST_IRQ_ACK: kind_dec = CY_IRQ_ACK;
      ST_IO_RD: kind_dec = CY_IO_RD;
      ST_IO_WR: kind_dec = CY_IO_WR;
      ST_HALT: kind_dec = CY_HALT;
      ST_FETCH: kind_dec = CY_MEM_RD;
      ST_MEM_RD: kind_dec = CY_MEM_RD;
      ST_MEM_WR: kind_dec = CY_MEM_WR;
      ST_PASSIVE: kind_dec = CY_NONE;
    endcase
  end

  // A cycle starts on passive-to-active status; passive status ends it from any phase.
  always_comb begin
    phase_nxt = phase_r;
    kind_nxt = kind_r;
    if (status == ST_PASSIVE) begin
      phase_nxt = PH_IDLE;
      kind_nxt = CY_NONE;
    end else begin
      unique case (phase_r)
        PH_IDLE: begin
          if (status_prev_r == ST_PASSIVE) begin
            phase_nxt = PH_ADDR;
            kind_nxt = kind_dec;
          end
        end
        PH_ADDR: phase_nxt = PH_CMD;
        PH_CMD: phase_nxt = PH_LATE;
        PH_LATE: phase_nxt = PH_LATE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_prev_r <= ST_PASSIVE;
      phase_r <= PH_IDLE;
      kind_r <= CY_NONE;
    end else begin
      status_prev_r <= status;
      phase_r <= phase_nxt;
      kind_r <= kind_nxt;
    end
  end

  assign early = (phase_nxt == PH_CMD) || (phase_nxt == PH_LATE);
  assign late = (phase_nxt == PH_LATE);

  always_comb begin
    cmd_nxt = CMD_IDLE;
    cmd_nxt.irq_ack_strobe_n = !(early && kind_nxt == CY_IRQ_ACK && io_ok);
    cmd_nxt.io_read_strobe_n = !(early && kind_nxt == CY_IO_RD && io_ok);
    cmd_nxt.early_io_write_strobe_n = !(early && kind_nxt == CY_IO_WR && io_ok);
    cmd_nxt.io_write_strobe_n = !(late && kind_nxt == CY_IO_WR && io_ok);
    cmd_nxt.mem_read_strobe_n = !(early && kind_nxt == CY_MEM_RD && mem_ok);
    cmd_nxt.early_mem_write_strobe_n = !(early && kind_nxt == CY_MEM_WR && mem_ok);
    cmd_nxt.mem_write_strobe_n = !(late && kind_nxt == CY_MEM_WR && mem_ok);
  end

  // All outputs are registered, so nothing moves between clock edges.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_n <= CMD_IDLE;
    end else begin
      cmd_n <= cmd_nxt;
    end
  end

  // Enables are low while the pin is driven.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_oe_n <= CMD_IDLE;
    end else begin
      cmd_oe_n.mem_read_strobe_n <= arbiter_grant_n;
      cmd_oe_n.mem_write_strobe_n <= arbiter_grant_n;
      cmd_oe_n.early_mem_write_strobe_n <= arbiter_grant_n;
      cmd_oe_n.io_read_strobe_n <= arbiter_grant_n && !io_bus_mode_select;
      cmd_oe_n.io_write_strobe_n <= arbiter_grant_n && !io_bus_mode_select;
      cmd_oe_n.early_io_write_strobe_n <= arbiter_grant_n && !io_bus_mode_select;
      cmd_oe_n.irq_ack_strobe_n <= arbiter_grant_n && !io_bus_mode_select;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      address_strobe <= 1'b0;
    end else begin
      address_strobe <= (phase_nxt == PH_ADDR);
    end
  end

  // In I/O bus mode the I/O cycles use the peripheral enable, not the main one.
  logic io_kind;
  assign io_kind = (kind_nxt == CY_IRQ_ACK) || (kind_nxt == CY_IO_RD) || (kind_nxt == CY_IO_WR);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      transceiver_enable <= 1'b0;
    end else begin
      transceiver_enable <= early && command_gate && (kind_nxt != CY_HALT)
                            && !(io_bus_mode_select && io_kind);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      transceiver_direction <= 1'b0;
    end else begin
      transceiver_direction <= (phase_nxt != PH_IDLE)
                               && (kind_nxt == CY_IO_WR || kind_nxt == CY_MEM_WR);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dual_enable <= 1'b0;
    end else if (io_bus_mode_select) begin
      dual_enable <= !(early && io_kind && command_gate);
    end else begin
      dual_enable <= (phase_nxt != PH_IDLE) && (kind_nxt == CY_IRQ_ACK);
    end
  end

  a_strobe_one_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
    address_strobe |=> !address_strobe) else $error("address strobe longer than one cycle");
  a_strobe_on_start: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(address_strobe) |-> $past(status_prev_r) == ST_PASSIVE && $past(status) != ST_PASSIVE)
    else $error("address strobe without cycle start");
  a_early_io_lead: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(cmd_n.io_write_strobe_n) |-> !$past(cmd_n.early_io_write_strobe_n))
    else $error("io write not preceded by early io write");
  a_early_mem_lead: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(cmd_n.mem_write_strobe_n) |-> !$past(cmd_n.early_mem_write_strobe_n))
    else $error("mem write not preceded by early mem write");
  a_gate_blocks_all: assert property (@(posedge core_clk) disable iff (!arst_n)
    !command_gate |=> cmd_n == CMD_IDLE && !transceiver_enable)
    else $error("gate low left outputs active");
  a_sys_float_all: assert property (@(posedge core_clk) disable iff (!arst_n)
    (arbiter_grant_n && !io_bus_mode_select) |=> cmd_oe_n == CMD_IDLE)
    else $error("system mode grant high did not float all");
  a_io_float_mem: assert property (@(posedge core_clk) disable iff (!arst_n)
    (arbiter_grant_n && io_bus_mode_select) |=> cmd_oe_n.mem_read_strobe_n && !cmd_oe_n.io_read_strobe_n)
    else $error("io mode float set wrong");
  a_grant_hold_mem: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(cmd_n.mem_read_strobe_n) |-> !$past(arbiter_grant_n, 2) && !$past(arbiter_grant_n, 5))
    else $error("memory read too soon after grant");
  a_direction_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    !cmd_n.io_read_strobe_n |-> !transceiver_direction)
    else $error("direction high during read");
  a_passive_ends: assert property (@(posedge core_clk) disable iff (!arst_n)
    status == ST_PASSIVE |=> cmd_n == CMD_IDLE && !transceiver_enable)
    else $error("passive status left command active");
  c_mem_write: cover property (@(posedge core_clk) disable iff (!arst_n) $fell(cmd_n.mem_write_strobe_n));
  c_io_read: cover property (@(posedge core_clk) disable iff (!arst_n) $fell(cmd_n.io_read_strobe_n));
  c_irq_ack: cover property (@(posedge core_clk) disable iff (!arst_n) $fell(cmd_n.irq_ack_strobe_n));
  c_io_mode_io_wr: cover property (@(posedge core_clk) disable iff (!arst_n)
    io_bus_mode_select && arbiter_grant_n && !cmd_n.io_write_strobe_n);
endmodule
`default_nettype wire

// ### core/cbc_grant_delay.sv
// Holds off command activity after the arbiter grant falls.
// Assumes the grant input is synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module cbc_grant_delay
  import cbc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = GRANT_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic arbiter_grant_n,
  output logic grant_ok
);
  logic [7:0] hold_r;
  logic [7:0] low_run_r;

  // The count restarts at every high sample, so a glitch of grant re-arms the full hold.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_r <= 8'(HOLD_CYC);
    end else if (arbiter_grant_n) begin
      hold_r <= 8'(HOLD_CYC);
    end else if (hold_r != 8'h00) begin
      hold_r <= hold_r - 8'h01;
    end
  end

  assign grant_ok = (hold_r == 8'h00);

  // Checker helper: counts consecutive low grant samples, independent of the hold counter.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_run_r <= 8'h00;
    end else if (arbiter_grant_n) begin
      low_run_r <= 8'h00;
    end else if (low_run_r != 8'hFF) begin
      low_run_r <= low_run_r + 8'h01;
    end
  end

  // The grant may rise while grant_ok still stands; the pin float covers that edge.
  a_hold_after_grant: assert property (@(posedge core_clk) disable iff (!arst_n)
    grant_ok |-> low_run_r >= 8'(HOLD_CYC))
    else $error("grant_ok raised before the hold time");
endmodule
`default_nettype wire

// ### core/cbc_pkg.sv
// Shared constants and types for the CPU bus command controller.
// Assumes the core clock is the CPU clock itself, at 40 MHz.
package cbc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned GRANT_HOLD_NS = 90;
  // A least time, so it rounds up to whole cycles.
  localparam int unsigned GRANT_HOLD_CYC = (GRANT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] ST_IRQ_ACK = 3'h0;
  localparam logic [2:0] ST_IO_RD = 3'h1;
  localparam logic [2:0] ST_IO_WR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_FETCH = 3'h4;
  localparam logic [2:0] ST_MEM_RD = 3'h5;
  localparam logic [2:0] ST_MEM_WR = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;
  typedef enum logic [2:0] {CY_NONE, CY_HALT, CY_IRQ_ACK, CY_IO_RD, CY_IO_WR, CY_MEM_RD, CY_MEM_WR} cbc_kind_t;
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_LATE} cbc_phase_t;
  typedef struct packed {
    logic io_write_strobe_n;
    logic early_io_write_strobe_n;
    logic io_read_strobe_n;
    logic mem_write_strobe_n;
    logic early_mem_write_strobe_n;
    logic mem_read_strobe_n;
    logic irq_ack_strobe_n;
  } cbc_cmd_t;
  localparam cbc_cmd_t CMD_IDLE = 7'h7F;
endpackage

// ### tb/cbc_cpu_model.sv
// CPU side model: status drivers with the status pull-ups, plus the external address latch.
// Assumes the bench changes code and drive only at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module cbc_cpu_model (
  input wire logic [2:0] code,
  input wire logic drive,
  input wire logic address_strobe,
  output logic cpu_status_bit0_n,
  output logic cpu_status_bit1_n,
  output logic cpu_status_bit2_n,
  output logic cpu_status_float,
  output logic [2:0] latched_code
);
  // A released bus shows the inverse of the last code, so only the float flag keeps it passive.
  assign {cpu_status_bit2_n, cpu_status_bit1_n, cpu_status_bit0_n} = drive ? code : ~code;
  assign cpu_status_float = !drive;
  // The latch takes the address on the trailing edge of the strobe.
  always_ff @(negedge address_strobe) begin
    latched_code <= code;
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the bus command controller.
// Assumes the default grant hold count; inputs change at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cbc_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] code = 3'h7;
  logic drive = 1'b0;
  logic arbiter_grant_n = 1'b0;
  logic command_gate = 1'b1;
  logic io_bus_mode_select = 1'b0;
  logic st_b0_n, st_b1_n, st_b2_n, status_float, address_strobe, transceiver_enable, transceiver_direction;
  logic dual_enable;
  logic [2:0] latched_code;
  cbc_cmd_t cmd_n, cmd_oe_n;
  int mismatches = 0;
  int compares = 0;
  cbc_bus_controller i_cbc_bus_controller (.core_clk(core_clk), .arst_n(arst_n), .cpu_status_bit0_n(st_b0_n),
    .cpu_status_bit1_n(st_b1_n), .cpu_status_bit2_n(st_b2_n), .cpu_status_float(status_float),
    .arbiter_grant_n(arbiter_grant_n), .command_gate(command_gate), .io_bus_mode_select(io_bus_mode_select),
    .cmd_n(cmd_n), .cmd_oe_n(cmd_oe_n), .address_strobe(address_strobe), .transceiver_enable(transceiver_enable),
    .transceiver_direction(transceiver_direction), .dual_enable(dual_enable));
  cbc_cpu_model i_cbc_cpu_model (.code(code), .drive(drive), .address_strobe(address_strobe),
    .cpu_status_bit0_n(st_b0_n), .cpu_status_bit1_n(st_b1_n), .cpu_status_bit2_n(st_b2_n),
    .cpu_status_float(status_float), .latched_code(latched_code));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic final_report();
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk1(input string name, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic chk7(input string name, input logic [6:0] e, input logic [6:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  // Strobe pattern per status code; late adds the normal write one clock after the early one.
  function automatic logic [6:0] exp_cmd(input logic [2:0] c, input logic late);
    case (c)
      3'h0: exp_cmd = 7'h7E;
      3'h1: exp_cmd = 7'h6F;
      3'h2: exp_cmd = late ? 7'h1F : 7'h5F;
      3'h4, 3'h5: exp_cmd = 7'h7D;
      3'h6: exp_cmd = late ? 7'h73 : 7'h7B;
      default: exp_cmd = 7'h7F;
    endcase
  endfunction
  task automatic run_cycle(input logic [2:0] c);
    logic io;
    io = io_bus_mode_select;
    @(negedge core_clk);
    code = c;
    drive = 1'b1;
    @(negedge core_clk);
    chk1("address_strobe", c != 3'h7, address_strobe);
    chk1("transceiver_direction", c == 3'h2 || c == 3'h6, transceiver_direction);
    @(negedge core_clk);
    if (c != 3'h7) chk7("latched_code", {4'h0, c}, {4'h0, latched_code});
    chk7("early cmd_n", exp_cmd(c, 1'b0), cmd_n);
    chk1("transceiver_enable", io ? (c inside {4, 5, 6}) : !(c inside {3, 7}), transceiver_enable);
    chk1("dual_enable", io ? !(c inside {0, 1, 2}) : (c == 3'h0), dual_enable);
    @(negedge core_clk);
    chk7("late cmd_n", exp_cmd(c, 1'b1), cmd_n);
    drive = 1'b0;
    repeat (2) @(negedge core_clk);
    chk7("idle cmd_n", 7'h7F, cmd_n);
    chk1("idle address_strobe", 1'b0, address_strobe);
  endtask
  task automatic sys_codes();
    for (int i = 0; i < 8; i++) run_cycle(3'(i));
  endtask
  task automatic io_codes();
    @(negedge core_clk);
    io_bus_mode_select = 1'b1;
    for (int i = 0; i < 8; i++) run_cycle(3'(i));
  endtask
  task automatic grant_float();
    @(negedge core_clk);
    io_bus_mode_select = 1'b0;
    arbiter_grant_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk7("system cmd_oe_n", 7'h7F, cmd_oe_n);
    io_bus_mode_select = 1'b1;
    repeat (2) @(negedge core_clk);
    chk7("io cmd_oe_n", 7'h0E, cmd_oe_n);
    run_cycle(ST_IO_RD);
    @(negedge core_clk);
    arbiter_grant_n = 1'b0;
    code = ST_MEM_RD;
    drive = 1'b1;
    // The read stays off for the full hold count of low grant samples, then shows one edge later.
    repeat (GRANT_HOLD_CYC) begin
      @(negedge core_clk);
      chk1("held mem_read_strobe_n", 1'b1, cmd_n.mem_read_strobe_n);
    end
    @(negedge core_clk);
    chk1("granted mem_read_strobe_n", 1'b0, cmd_n.mem_read_strobe_n);
    drive = 1'b0;
    io_bus_mode_select = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic gate_block();
    @(negedge core_clk);
    command_gate = 1'b0;
    code = ST_MEM_RD;
    drive = 1'b1;
    repeat (3) @(negedge core_clk);
    chk7("gated cmd_n", 7'h7F, cmd_n);
    chk1("gated transceiver_enable", 1'b0, transceiver_enable);
    drive = 1'b0;
    io_bus_mode_select = 1'b1;
    repeat (2) @(negedge core_clk);
    code = ST_IO_WR;
    drive = 1'b1;
    repeat (3) @(negedge core_clk);
    chk7("gated io cmd_n", 7'h7F, cmd_n);
    chk1("gated dual_enable", 1'b1, dual_enable);
    drive = 1'b0;
    io_bus_mode_select = 1'b0;
    command_gate = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    // The grant hold counter starts full after reset.
    repeat (6) @(negedge core_clk);
    sys_codes();
    io_codes();
    grant_float();
    gate_block();
    final_report();
  end
endmodule
`default_nettype wire
